// *** core/sbpi_pkg.sv ***
// package for the system bus parity and bus-init block
// assumes a single bus clock; pins active low on the wire, except the subphase-two line, which is high when asserted
package sbpi_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STATE = 4'hC;
    // status and mask bit positions
    localparam int ST_PARITY_ERR = 0;
    localparam int ST_INIT_SEEN = 1;
    localparam int ST_INIT_DRIVEN = 2;
    localparam int ST_WIDTH = 3;
    // control bit positions
    localparam int CTL_FORCE_INIT = 0;
    localparam int CTL_CHECK_EN = 1;
    // reset values
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [1:0] CONTROL_RESET = 2'h2;
    // bus-init hold time in bus clocks
    localparam logic [2:0] INIT_HOLD_CYCLES = 3'h4;
    // in-order queue counter width
    localparam int IOQ_WIDTH = 4;
    // arbitration and request-issue states
    typedef enum logic [1:0] {ARB_IDLE, ARB_REQUEST, ARB_OWNER} sbpi_arb_type;
    typedef enum logic [1:0] {TX_IDLE, TX_SUB1, TX_SUB2} sbpi_tx_type;
endpackage : sbpi_pkg

// *** core/sbpi_par_if.sv ***
// interface carrying one request subphase to a parity unit
// assumes asserted lines are given as ones, not as pin levels
`timescale 1ns/1ps
interface sbpi_par_if;
    logic [35:3] addr; // address lines, one = asserted
    logic [4:0] req; // request-type lines, one = asserted
    logic sub2; // high in the second subphase
    logic [1:0] parity_pin; // resulting parity pin levels
    modport calc (input addr, input req, input sub2, output parity_pin);
    modport user (output addr, output req, output sub2, input parity_pin);
endinterface : sbpi_par_if

// *** core/sbpi_parity.sv ***
// combinational request parity for one subphase
// assumes the caller converts pin levels into asserted-high form
`timescale 1ns/1ps
module sbpi_parity (
    // subphase lines in, parity pins out
    sbpi_par_if.calc par
);
    logic upper_odd; // odd count on address 35..24
    logic lower_odd; // odd count on address 23..3 and type lines

    // an even count of asserted lines gives a high pin
    always_comb begin
        upper_odd = ^par.addr[35:24];
        lower_odd = (^par.addr[23:3]) ^ (^par.req);
        if (par.sub2) begin
            par.parity_pin = {~upper_odd, ~lower_odd};
        end else begin
            par.parity_pin = {~lower_odd, ~upper_odd};
        end
    end
endmodule : sbpi_parity

// *** core/sbpi_top.sv ***
// bus request parity generation/check and bus-init signalling
// assumes CLK_I is the true bus clock phase; straps are stable at reset release
`timescale 1ns/1ps
// Operation
// - parity pin high for even asserted count
// - subphase two lines carry type information
// - everything timed on bus clock rising edge
// - drive bus-init on fatal bus condition
// - observed bus-init resets lock and arbitration
// - in-order queue untouched by bus-init
// - re-arbitrate and finish pending after bus-init
module sbpi_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // power-on straps
    input wire logic INIT_DRIVE_STRAP_I,
    input wire logic INIT_OBSERVE_STRAP_I,
    // register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WRITE_I,
    input wire logic REG_READ_I,
    output logic [31:0] REG_RDATA_O,
    output logic IRQ_O,
    // request issue from the agent core
    input wire logic ISSUE_I,
    input wire logic [35:3] ISSUE_ADDR_I,
    input wire logic [4:0] ISSUE_TYPE_I,
    input wire logic [35:3] ISSUE_INFO_I,
    input wire logic ISSUE_LOCK_I,
    output logic ISSUE_READY_O,
    input wire logic UNLOCK_I,
    input wire logic COMPLETE_I,
    // arbitration pins
    output logic BUS_REQ_N_O,
    input wire logic BUS_GRANT_N_I,
    // request pins driven by this agent
    output logic [35:3] ADDR_N_O,
    output logic [4:0] REQ_N_O,
    output logic [1:0] PARITY_N_O,
    output logic REQ_OE_O,
    // request pins seen from other agents
    input wire logic REQ_STROBE_N_I,
    input wire logic REQ_SUB2_I,
    input wire logic [35:3] ADDR_N_I,
    input wire logic [4:0] REQ_N_I,
    input wire logic [1:0] PARITY_N_I,
    // open-drain bus-init line
    input wire logic BUS_INIT_N_I,
    output logic BUS_INIT_N_O,
    output logic BUS_INIT_OE_O
);
    // two-stage synchronisers for every bus pin input, not the straps
    logic [43:0] pin_meta; // first stage, read only by second
    logic [43:0] pin_sync; // second stage
    logic strobe_s, sub2_s, grant_s, init_seen_s; // decoded synced pins
    logic [35:3] addr_s; // synced address pins
    logic [4:0] req_s; // synced type pins
    logic [1:0] parity_s; // synced parity pins

    // straps caught once after release
    logic strap_taken, drive_en, observe_en;
    // registers
    logic [2:0] status, next_status, mask, next_mask;
    logic [1:0] control, next_control;
    logic [31:0] next_rdata;
    // bus-init driver
    logic [2:0] init_count, next_init_count;
    logic init_event, init_observed;
    // arbitration, lock and issue
    sbpi_pkg::sbpi_arb_type arb, next_arb;
    sbpi_pkg::sbpi_tx_type tx, next_tx;
    logic lock_active, next_lock_active;
    logic pending, next_pending, pend_lock, next_pend_lock;
    logic [35:3] pend_addr, next_pend_addr, pend_info, next_pend_info;
    logic [4:0] pend_type, next_pend_type;
    logic [sbpi_pkg::IOQ_WIDTH-1:0] in_order_queue, next_ioq; // in_order_queue depth
    logic [35:3] next_addr_n;
    logic [4:0] next_req_n;
    logic [1:0] next_parity_n;
    logic next_oe, parity_err;

    sbpi_par_if gen_if (); // parity for what we drive
    sbpi_par_if chk_if (); // parity for what we see

    sbpi_parity u_gen (.par(gen_if.calc));
    sbpi_parity u_chk (.par(chk_if.calc));

    // pins are foreign to our logic, so two flops first
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= {REQ_STROBE_N_I, ~REQ_SUB2_I, BUS_GRANT_N_I, BUS_INIT_N_I,
                         ADDR_N_I, REQ_N_I, PARITY_N_I};
            pin_sync <= pin_meta;
        end
    end
    assign strobe_s = ~pin_sync[43];
    assign sub2_s = ~pin_sync[42];
    assign grant_s = ~pin_sync[41];
    assign init_seen_s = ~pin_sync[40];
    assign addr_s = pin_sync[39:7];
    assign req_s = pin_sync[6:2];
    assign parity_s = pin_sync[1:0];

    // straps are levels, so they are taken by a clocked process after release
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            strap_taken <= 1'b0;
            drive_en <= 1'b0;
            observe_en <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            drive_en <= INIT_DRIVE_STRAP_I;
            observe_en <= INIT_OBSERVE_STRAP_I;
        end
    end

    // check parity of a seen subphase; pins low mean asserted
    assign chk_if.addr = ~addr_s;
    assign chk_if.req = ~req_s;
    assign chk_if.sub2 = sub2_s;
    assign parity_err = strobe_s && control[sbpi_pkg::CTL_CHECK_EN]
                        && (chk_if.parity_pin != parity_s);

    // any unrecoverable condition starts the driver
    assign init_event = drive_en && init_count == 3'h0
                        && (parity_err || control[sbpi_pkg::CTL_FORCE_INIT]);
    // with observation off nothing recovers
    assign init_observed = observe_en && init_seen_s;

    // driver hold count
    always_comb begin
        next_init_count = init_count;
        if (init_event) begin
            next_init_count = sbpi_pkg::INIT_HOLD_CYCLES;
        end else if (init_count != 3'h0) begin
            next_init_count = init_count - 3'h1;
        end
    end
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            init_count <= 3'h0;
        end else begin
            init_count <= next_init_count;
        end
    end
    // open-drain: drive low only while holding
    assign BUS_INIT_N_O = 1'b0;
    assign BUS_INIT_OE_O = init_count != 3'h0;

    // arbitration, lock, pending request and issue sequence
    always_comb begin
        next_arb = arb;
        next_tx = tx;
        next_lock_active = lock_active;
        next_pending = pending;
        next_pend_lock = pend_lock;
        next_pend_addr = pend_addr;
        next_pend_info = pend_info;
        next_pend_type = pend_type;
        next_ioq = in_order_queue;
        next_oe = 1'b0;
        next_addr_n = '1;
        next_req_n = '1;
        next_parity_n = '1;
        if (ISSUE_I && !pending) begin
            next_pending = 1'b1;
            next_pend_addr = ISSUE_ADDR_I;
            next_pend_info = ISSUE_INFO_I;
            next_pend_type = ISSUE_TYPE_I;
            next_pend_lock = ISSUE_LOCK_I;
        end
        if (UNLOCK_I) begin
            next_lock_active = 1'b0;
        end
        if (COMPLETE_I && in_order_queue != '0) begin
            next_ioq = in_order_queue - 1'b1;
        end
        unique case (arb)
            sbpi_pkg::ARB_IDLE: begin
                if (pending) begin
                    next_arb = sbpi_pkg::ARB_REQUEST;
                end
            end
            sbpi_pkg::ARB_REQUEST: begin
                if (grant_s) begin
                    next_arb = sbpi_pkg::ARB_OWNER;
                    next_tx = sbpi_pkg::TX_SUB1;
                end
            end
            sbpi_pkg::ARB_OWNER: begin
                unique case (tx)
                    sbpi_pkg::TX_IDLE: next_arb = sbpi_pkg::ARB_IDLE;
                    sbpi_pkg::TX_SUB1: begin
                        next_oe = 1'b1;
                        next_addr_n = ~pend_addr;
                        next_req_n = ~pend_type;
                        next_parity_n = gen_if.parity_pin;
                        next_tx = sbpi_pkg::TX_SUB2;
                    end
                    sbpi_pkg::TX_SUB2: begin
                        next_oe = 1'b1;
                        next_addr_n = ~pend_info;
                        next_req_n = ~pend_type;
                        next_parity_n = gen_if.parity_pin;
                        next_tx = sbpi_pkg::TX_IDLE;
                        next_pending = 1'b0;
                        next_lock_active = lock_active | pend_lock;
                        next_ioq = in_order_queue + 1'b1;
                        if (COMPLETE_I && in_order_queue != '0) begin
                            next_ioq = in_order_queue;
                        end
                    end
                endcase
            end
        endcase
        // bus-init: drop lock and arbitration, keep queue and pending
        if (init_observed) begin
            next_arb = sbpi_pkg::ARB_IDLE;
            next_tx = sbpi_pkg::TX_IDLE;
            next_lock_active = 1'b0;
            next_pending = pending | (ISSUE_I && !pending);
            next_ioq = in_order_queue;
            next_oe = 1'b0;
            next_addr_n = '1;
            next_req_n = '1;
            next_parity_n = '1;
        end
    end
    // generator sees the subphase about to be driven
    assign gen_if.addr = (tx == sbpi_pkg::TX_SUB2) ? pend_info : pend_addr;
    assign gen_if.req = pend_type;
    assign gen_if.sub2 = tx == sbpi_pkg::TX_SUB2;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            arb <= sbpi_pkg::ARB_IDLE;
            tx <= sbpi_pkg::TX_IDLE;
            lock_active <= 1'b0;
            pending <= 1'b0;
            pend_lock <= 1'b0;
            pend_addr <= '0;
            pend_info <= '0;
            pend_type <= '0;
            in_order_queue <= '0;
            REQ_OE_O <= 1'b0;
            ADDR_N_O <= '1;
            REQ_N_O <= '1;
            PARITY_N_O <= '1;
        end else begin
            arb <= next_arb;
            tx <= next_tx;
            lock_active <= next_lock_active;
            pending <= next_pending;
            pend_lock <= next_pend_lock;
            pend_addr <= next_pend_addr;
            pend_info <= next_pend_info;
            pend_type <= next_pend_type;
            in_order_queue <= next_ioq;
            REQ_OE_O <= next_oe;
            ADDR_N_O <= next_addr_n;
            REQ_N_O <= next_req_n;
            PARITY_N_O <= next_parity_n;
        end
    end
    assign BUS_REQ_N_O = ~(arb == sbpi_pkg::ARB_REQUEST || arb == sbpi_pkg::ARB_OWNER);
    assign ISSUE_READY_O = ~pending;

    // register writes and sticky status; a new event beats the clear
    always_comb begin
        next_status = status;
        next_mask = mask;
        next_control = control;
        next_rdata = 32'h0000_0000;
        if (REG_WRITE_I) begin
            unique case (REG_ADDR_I)
                sbpi_pkg::ADDR_STATUS: next_status = status & ~REG_WDATA_I[2:0];
                sbpi_pkg::ADDR_MASK: next_mask = REG_WDATA_I[2:0];
                sbpi_pkg::ADDR_CONTROL: next_control = REG_WDATA_I[1:0];
                default: ;
            endcase
        end
        // force bit is one-shot once the driver takes it
        if (init_event) begin
            next_control[sbpi_pkg::CTL_FORCE_INIT] = 1'b0;
        end
        if (parity_err) begin
            next_status[sbpi_pkg::ST_PARITY_ERR] = 1'b1;
        end
        if (init_observed) begin
            next_status[sbpi_pkg::ST_INIT_SEEN] = 1'b1;
        end
        if (init_event) begin
            next_status[sbpi_pkg::ST_INIT_DRIVEN] = 1'b1;
        end
        if (REG_READ_I) begin
            unique case (REG_ADDR_I)
                sbpi_pkg::ADDR_STATUS: next_rdata = {29'h0, status};
                sbpi_pkg::ADDR_MASK: next_rdata = {29'h0, mask};
                sbpi_pkg::ADDR_CONTROL: next_rdata = {30'h0, control};
                sbpi_pkg::ADDR_STATE: next_rdata = {20'h0, in_order_queue, observe_en, drive_en,
                                                    lock_active, pending, tx, arb};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            status <= 3'h0;
            mask <= sbpi_pkg::MASK_RESET;
            control <= sbpi_pkg::CONTROL_RESET;
            REG_RDATA_O <= 32'h0000_0000;
        end else begin
            status <= next_status;
            mask <= next_mask;
            control <= next_control;
            REG_RDATA_O <= next_rdata;
        end
    end
    // level interrupt while any unmasked status bit is set
    assign IRQ_O = |(status & mask);
endmodule : sbpi_top

// *** bench/sbpi_checker.sv ***
// port checker for sbpi_top: parity, subphases, bus-init, read port
// assumes one bus clock and asynchronous active-low reset
`timescale 1ns/1ps
module sbpi_checker (
    // clock, reset, strap
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic INIT_OBSERVE_STRAP_I,
    // watched ports
    input wire logic REG_READ_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic ISSUE_READY_O,
    input wire logic BUS_REQ_N_O,
    input wire logic [35:3] ADDR_N_O,
    input wire logic [4:0] REQ_N_O,
    input wire logic [1:0] PARITY_N_O,
    input wire logic REQ_OE_O,
    input wire logic BUS_INIT_N_I,
    input wire logic BUS_INIT_N_O,
    input wire logic BUS_INIT_OE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // group parities: even widths, so even lows means even ones
    wire hi_par = ~^ADDR_N_O[35:24];
    wire lo_par = ~^{ADDR_N_O[23:3], REQ_N_O};
    a_sub1_parity:
        assert property (REQ_OE_O && !$past(REQ_OE_O) |-> PARITY_N_O == {lo_par, hi_par})
        else $error("first subphase parity wrong");
    a_sub2_parity:
        assert property ($past(REQ_OE_O) && REQ_OE_O |-> PARITY_N_O == {hi_par, lo_par})
        else $error("second subphase parity wrong");
    a_two_subphases:
        assert property ($rose(REQ_OE_O) |=> REQ_OE_O ##1 !REQ_OE_O)
        else $error("request not two cycles");
    a_idle_lines:
        assert property (!REQ_OE_O |-> &{ADDR_N_O, REQ_N_O, PARITY_N_O})
        else $error("request pins not idle");
    a_drive_owner:
        assert property ($rose(REQ_OE_O) |-> $past(BUS_REQ_N_O) == 1'b0)
        else $error("drove without requesting");
    a_ready_after:
        assert property ($fell(REQ_OE_O) |-> ISSUE_READY_O)
        else $error("not ready after request");
    a_init_hold:
        assert property ($rose(BUS_INIT_OE_O) |-> BUS_INIT_OE_O[*4] ##1 !BUS_INIT_OE_O)
        else $error("bus-init hold length wrong");
    a_init_level:
        assert property (BUS_INIT_OE_O |-> !BUS_INIT_N_O)
        else $error("bus-init driven high");
    a_arb_reset:
        assert property ($fell(BUS_INIT_N_I) && INIT_OBSERVE_STRAP_I && !ISSUE_READY_O
            && !REQ_OE_O |-> ##[1:12] BUS_REQ_N_O ##[1:8] !BUS_REQ_N_O)
        else $error("no re-arbitration after bus-init");
    a_pending_kept:
        assert property ($fell(BUS_INIT_N_I) && !ISSUE_READY_O && !REQ_OE_O
            |=> !ISSUE_READY_O [*6])
        else $error("pending request lost");
    a_rdata_quiet:
        assert property (!$past(REG_READ_I) |-> REG_RDATA_O == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule : sbpi_checker

bind sbpi_top sbpi_checker u_sbpi_checker (.CLK_I, .ARST_N_I, .INIT_OBSERVE_STRAP_I,
    .REG_READ_I, .REG_RDATA_O, .ISSUE_READY_O, .BUS_REQ_N_O, .ADDR_N_O, .REQ_N_O,
    .PARITY_N_O, .REQ_OE_O, .BUS_INIT_N_I, .BUS_INIT_N_O, .BUS_INIT_OE_O);

// *** bench/sbpi_peer.sv ***
// far-side model: arbiter, another agent's requests, bus-init wire
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module sbpi_peer (
    // clock
    input wire logic clk_i,
    // from the block
    input wire logic bus_req_n_i,
    input wire logic init_oe_i,
    // arbitration and bus-init
    output logic grant_n_o,
    output logic bus_init_n_o,
    // other agent request lines, pin levels
    output logic strobe_n_o,
    output logic sub2_o,
    output logic [35:3] addr_n_o,
    output logic [4:0] req_n_o,
    output logic [1:0] par_n_o
);
    int lag = 0; // grant delay in cycles
    bit hold = 0; // withhold grant to stall the block
    logic [7:0] req_hist = 8'hff; // request pin history
    logic init_drv = 1'b0; // peer pulls bus-init low
    // open drain with pull-up, either party pulls low
    assign bus_init_n_o = !(init_oe_i || init_drv);
    initial begin
        {grant_n_o, strobe_n_o, sub2_o, addr_n_o, req_n_o, par_n_o} = '1;
    end
    // grant follows the request pin after a lag
    always @(posedge clk_i) begin
        req_hist <= {req_hist[6:0], bus_req_n_i};
        grant_n_o <= hold || req_hist[lag];
    end
    // pin levels of parity, high for even lows; groups swap in sub2
    function automatic logic [1:0] par(input logic [35:3] a, input logic [4:0] r, input bit s2);
        logic h;
        logic l;
        h = ~^a[35:24];
        l = ~^{a[23:3], r};
        return s2 ? {h, l} : {l, h};
    endfunction : par
    // address then type information, bad flips a parity pin
    task automatic send(input logic [35:3] a, input logic [35:3] i, input logic [4:0] r,
        input bit bad);
        {strobe_n_o, sub2_o, addr_n_o, req_n_o} <= {2'b00, a, r};
        par_n_o <= par(a, r, 1'b0) ^ {1'b0, bad};
        @(posedge clk_i);
        {sub2_o, addr_n_o, par_n_o} <= {1'b1, i, par(i, r, 1'b1)};
        @(posedge clk_i);
        // released lines float to the pull-up level
        {strobe_n_o, sub2_o, addr_n_o, req_n_o, par_n_o} <= '1;
    endtask : send
    // bus-init pulse, done whatever the block's observe setting
    task automatic pulse_init(input int n);
        init_drv <= 1'b1;
        repeat (n) @(posedge clk_i);
        init_drv <= 1'b0;
    endtask : pulse_init
endmodule : sbpi_peer

// *** bench/sbpi_top_tb.sv ***
// self-checking bench for sbpi_top against an integer and queue model
// assumes the checker binds itself and the peer answers the bus
`timescale 1ns/1ps
module sbpi_top_tb;
    logic clk = 0, arst_n = 0, drv = 0, obs = 0, rd_s = 0, wr_s = 0, issue = 0, lock = 0;
    logic complete = 0, irq, ready, breq_n, grant_n, req_oe, stb_n, sub2, init_n, init_oe;
    logic [3:0] ra = '0;
    logic [31:0] wd = '0, rdata;
    logic [35:3] ia = '0, ii = '0, a_n, p_a_n;
    logic [4:0] it = '0, r_n, p_r_n;
    logic [1:0] par_n, p_par_n;
    logic [15:0] lfsr = 16'hc10f; // seed 49423
    logic [70:0] q[$]; // expected pin words per request
    int err_count = 0, cmp_count = 0, cyc = 0, in_order_queue = 0, n = 0;
    sbpi_top u_sbpi_top (.CLK_I(clk), .ARST_N_I(arst_n), .INIT_DRIVE_STRAP_I(drv),
        .INIT_OBSERVE_STRAP_I(obs), .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WRITE_I(wr_s),
        .REG_READ_I(rd_s), .REG_RDATA_O(rdata), .IRQ_O(irq), .ISSUE_I(issue),
        .ISSUE_ADDR_I(ia), .ISSUE_TYPE_I(it), .ISSUE_INFO_I(ii), .ISSUE_LOCK_I(lock),
        .ISSUE_READY_O(ready), .UNLOCK_I(1'b0), .COMPLETE_I(complete),
        .BUS_REQ_N_O(breq_n), .BUS_GRANT_N_I(grant_n), .ADDR_N_O(a_n), .REQ_N_O(r_n),
        .PARITY_N_O(par_n), .REQ_OE_O(req_oe), .REQ_STROBE_N_I(stb_n), .REQ_SUB2_I(sub2),
        .ADDR_N_I(p_a_n), .REQ_N_I(p_r_n), .PARITY_N_I(p_par_n), .BUS_INIT_N_I(init_n),
        .BUS_INIT_N_O(), .BUS_INIT_OE_O(init_oe));
    sbpi_peer u_peer (.clk_i(clk), .bus_req_n_i(breq_n), .init_oe_i(init_oe),
        .grant_n_o(grant_n), .bus_init_n_o(init_n), .strobe_n_o(stb_n), .sub2_o(sub2),
        .addr_n_o(p_a_n), .req_n_o(p_r_n), .par_n_o(p_par_n));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        if (++cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    task automatic check(input string w, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        {ra, wd, wr_s} <= {a, d, 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // read, data looked at mid-cycle after the strobe, masked compare
    task automatic rc(input string w, input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e);
        {ra, rd_s} <= {a, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        check(w, rdata & m, e);
        @(posedge clk);
    endtask : rc
    // one request through the bus, optionally stalled across a bus-init pulse
    task automatic xfer(input bit lk, input bit stall);
        logic [70:0] e;
        e = {33'({rnd(), rnd(), rnd()}), 33'({rnd(), rnd(), rnd()}), 5'(rnd())};
        u_peer.lag = int'(rnd() % 4);
        u_peer.hold = stall;
        q.push_back(~e); // pin levels of address, information, type
        {ia, ii, it, issue, lock} <= {e, 1'b1, lk};
        @(posedge clk);
        issue <= 1'b0;
        @(negedge clk);
        check("ready low", ready, 1'b0);
        if (stall) begin
            repeat (4) @(posedge clk);
            rc("state pre", sbpi_pkg::ADDR_STATE, 32'h0000_0030, 32'h0000_0030);
            u_peer.pulse_init(4);
            repeat (8) @(posedge clk);
            rc("state post", sbpi_pkg::ADDR_STATE, 32'h0000_00f0, {obs, drv, !obs, 5'h10});
            check("still pending", ready, 1'b0);
            rc("init seen", sbpi_pkg::ADDR_STATUS, 32'h0000_0002, {obs, 1'b0});
            wr(sbpi_pkg::ADDR_STATUS, 32'h0000_0007);
            u_peer.hold = 0;
        end
        n = 0;
        do @(negedge clk); while (req_oe !== 1'b1 && ++n < 60);
        e = q.pop_front();
        check("sub1 pins", {a_n, r_n}, {e[70:38], e[4:0]});
        check("sub1 par", par_n, u_peer.par(e[70:38], e[4:0], 1'b0));
        @(negedge clk);
        check("sub2 pins", {a_n, r_n}, {e[37:5], e[4:0]});
        check("sub2 par", par_n, u_peer.par(e[37:5], e[4:0], 1'b1));
        @(negedge clk);
        check("idle", {req_oe, ready}, 2'b01);
        in_order_queue++;
        @(posedge clk);
    endtask : xfer
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        for (int ph = 0; ph < 2; ph++) begin
            {arst_n, drv, obs, in_order_queue} <= {1'b0, !ph[0], !ph[0], 32'd0};
            repeat (9) @(posedge clk);
            @(negedge clk);
            check("reset outs", {rdata, irq, ready, breq_n, req_oe, init_oe}, 37'h0c);
            @(posedge clk);
            arst_n <= 1'b1;
            repeat (2) @(posedge clk);
            rc("mask", sbpi_pkg::ADDR_MASK, '1, 32'(sbpi_pkg::MASK_RESET));
            rc("control", sbpi_pkg::ADDR_CONTROL, '1, 32'(sbpi_pkg::CONTROL_RESET));
            wr(4'h2, 32'hffff_ffff);
            rc("unmapped", 4'h2, '1, 32'h0000_0000);
            repeat (5) xfer(1'b1, 1'b0);
            xfer(1'b1, 1'b1);
            rc("queue", sbpi_pkg::ADDR_STATE, 32'h0000_0f00, 32'(in_order_queue) << 8);
            complete <= 1'b1;
            repeat (2) @(posedge clk);
            complete <= 1'b0;
            rc("queue dec", sbpi_pkg::ADDR_STATE, 32'h0000_0f00, 32'(in_order_queue - 2) << 8);
            wr(sbpi_pkg::ADDR_MASK, 32'h0000_0007);
            @(posedge clk);
            // other agent requests: good, bad, bad, bad with checking off
            for (int k = 0; k < 4; k++) begin
                wr(sbpi_pkg::ADDR_CONTROL, {30'h0, k != 3, 1'b0});
                u_peer.send(~33'({rnd(), rnd(), rnd()}), 33'(rnd()), 5'(rnd()), k != 0);
                // own bus-init pulse is still being observed for a while; clear after it
                repeat (6) @(posedge clk);
                rc("par err", sbpi_pkg::ADDR_STATUS, 32'h0000_0001, {k != 0 && k != 3});
                check("irq", irq, k != 0 && k != 3);
                wr(sbpi_pkg::ADDR_STATUS, 32'h0000_0007);
                @(negedge clk);
                check("irq clear", irq, 1'b0);
                @(posedge clk);
            end
            wr(sbpi_pkg::ADDR_CONTROL, 32'h0000_0003);
            n = 0;
            repeat (12) @(negedge clk) n += int'(init_oe);
            check("init cycles", n, drv ? 4 : 0);
            @(posedge clk);
            rc("init stat", sbpi_pkg::ADDR_STATUS, 32'h0000_0006, {drv, drv & obs, 1'b0});
            check("irq init", irq, drv);
            wr(sbpi_pkg::ADDR_STATUS, 32'h0000_0007);
        end
        wrap_up();
    end
endmodule : sbpi_top_tb
